// file: src/fsr_consts.svh
`ifndef FSR_CONSTS_SVH
`define FSR_CONSTS_SVH

// --------------------------------------------------------------------------
// Command codes of the status bank
// --------------------------------------------------------------------------
`define FSR_CMD_SUMMARY      8'h79
`define FSR_CMD_VOUT_STATUS  8'h7A
`define FSR_CMD_TEMP_STATUS  8'h7D
`define FSR_CMD_COMM_STATUS  8'h7E
`define FSR_CMD_VENDOR       8'h80
`define FSR_CMD_MEAS_VOUT    8'h8B

// --------------------------------------------------------------------------
// Page numbers
// --------------------------------------------------------------------------
`define FSR_PAGE_GLOBAL      8'hFF

// --------------------------------------------------------------------------
// Summary word bit positions
// --------------------------------------------------------------------------
`define FSR_SUM_VOUT         15
`define FSR_SUM_VENDOR       12
`define FSR_SUM_PGLOST       11
`define FSR_SUM_MARGIN       8
`define FSR_SUM_CHANOFF      6
`define FSR_SUM_OVFAULT      5
`define FSR_SUM_TEMP         2
`define FSR_SUM_COMM         1

// --------------------------------------------------------------------------
// Byte field positions
// --------------------------------------------------------------------------
`define FSR_VOUT_OVF         7
`define FSR_VOUT_OVW         6
`define FSR_VOUT_UVW         5
`define FSR_VOUT_UVF         4
`define FSR_VOUT_TON         2
`define FSR_TEMP_OTF         7
`define FSR_TEMP_OTW         6
`define FSR_COMM_CMD         7
`define FSR_COMM_DATA        6
`define FSR_COMM_LOGFULL     0
`define FSR_VCH_OFF          7
`define FSR_VCH_MARGIN       3
`define FSR_VCH_PGLOST       2
`define FSR_VGL_LOCK         7
`define FSR_VGL_FAULTIN      6
`define FSR_VGL_WATCHDOG     4
`define FSR_VGL_CONTROL      3

// --------------------------------------------------------------------------
// Timing
// --------------------------------------------------------------------------
`define FSR_CLOCK_HZ         50000000
`define FSR_REFRESH_US       5000

`endif

// file: src/fsr_pkg.sv
package fsr_pkg;

    // Kind of page addressed by a read, one-hot.
    typedef enum logic [2:0] {
        FSR_PAGE_CHAN   = 3'h1,
        FSR_PAGE_GLOBAL = 3'h2,
        FSR_PAGE_BAD    = 3'h4
    } fsr_page_kind_t;

endpackage

// file: src/fsr_sticky.sv
`timescale 1ns/10ps

module fsr_sticky #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             reset_n,
    // Set and clear
    input  wire logic [WIDTH-1:0] setBits,
    input  wire logic             clearAll,
    // Latched flags
    output logic      [WIDTH-1:0] flags_q
);

    // --------------------------------------------------------------------
    // Latch
    // --------------------------------------------------------------------

    // A set in the clearing cycle wins, so no event or persisting
    // condition is lost to a clear.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            flags_q <= '0;
        end else begin
            flags_q <= (flags_q & ~{WIDTH{clearAll}}) | setBits;
        end
    end

endmodule

// file: src/fsr_status_bank.sv
// What this block does
// - Summary word returned as two bytes.
// - Bit 15: any voltage fault or warning, or turn-on fault.
// - Unused status bits always read zero.
// - Bit 12: any global vendor bit set.
// - Bit 11: OR of power-good-lost flags.
// - Bit 8: margining fault occurred.
// - Bit 6: OR of channel-off flags.
// - Bit 5: overvoltage fault occurred.
// - Bit 2 temperature, bit 1 communication.
// - Off and power-good-lost never raise alert.
// - Voltage byte bits 7,6,5,4,2 layout.
// - Voltage bits latch, re-set while persisting.
// - Temperature fault/warning bits 7,6 latched.
// - Comm bit 7: invalid command received.
// - Comm bit 6: invalid data received.
// - Comm bits re-set only on new events.
// - Comm bit 0 tracks log full live.
// - Overwrite mode clears full when space is freed.
// - Vendor byte content depends on page.
// - Measured voltage, two bytes, direct format.
// - Measured voltage refreshed every 5 ms.
// - Clear with condition present re-sets bit.
// - Channel off while enable held low.
// - Power-good-lost set from reset until good.
`timescale 1ns/10ps
`include "fsr_consts.svh"

module fsr_status_bank #(
    parameter int CHANNELS       = 16,
    parameter int REFRESH_CYCLES = `FSR_REFRESH_US * (`FSR_CLOCK_HZ / 1000000)
) (
    // Clock and reset
    input  wire logic                   clock,
    input  wire logic                   reset_n,
    // Read request from the command engine
    input  wire logic                   readReq,
    input  wire logic [7:0]             readCmd,
    input  wire logic [7:0]             readPage,
    input  wire logic                   clearFaults,
    input  wire logic                   badDataEvent,
    // Read answer
    output logic                        readValid_q,
    output logic [15:0]                 readData_q,
    output logic                        alertActive_q,
    // Per-channel voltage conditions and events
    input  wire logic [CHANNELS-1:0]    ovFault,
    input  wire logic [CHANNELS-1:0]    ovWarn,
    input  wire logic [CHANNELS-1:0]    uvWarn,
    input  wire logic [CHANNELS-1:0]    uvFault,
    input  wire logic [CHANNELS-1:0]    turnOnTimeFault,
    input  wire logic [CHANNELS-1:0]    marginFault,
    // Per-channel sequencing and power-good state
    input  wire logic [CHANNELS-1:0]    channelEnabled,
    input  wire logic [CHANNELS-1:0]    supplyEnableOutput,
    input  wire logic [CHANNELS-1:0]    aboveGoodOn,
    input  wire logic [CHANNELS-1:0]    belowGoodOff,
    input  wire logic [CHANNELS*16-1:0] measuredVolts,
    // Temperature conditions
    input  wire logic                   otFault,
    input  wire logic                   otWarn,
    // Fault log state
    input  wire logic                   logFull,
    input  wire logic                   logOverwriteEnable,
    input  wire logic                   logSpaceFreed,
    // Global vendor sources
    input  wire logic                   deviceLocked,
    input  wire logic                   faultInputEvent,
    input  wire logic                   watchdogResetEvent,
    input  wire logic                   controlOffEvent
);

    localparam int CH_W = (CHANNELS > 1) ? $clog2(CHANNELS) : 1;
    localparam int CNT_W = $clog2(REFRESH_CYCLES + 1);

    // ----------
    // Parameter checks
    // ----------

    // Pages at or above the channel count and below the global page are refused.
    if (CHANNELS < 1 || CHANNELS > 16) begin : gBadChannels
        $error("CHANNELS must be 1 to 16");
    end
    if (REFRESH_CYCLES < 1) begin : gBadRefresh
        $error("REFRESH_CYCLES must be at least 1");
    end

    // ----------
    // Page decode
    // ----------

    // Classifies the selected page; used by the read mux and error check.
    function automatic fsr_pkg::fsr_page_kind_t pageKind(input logic [7:0] page);
        if (page == `FSR_PAGE_GLOBAL) begin
            pageKind = fsr_pkg::FSR_PAGE_GLOBAL;
        end else if (page < 8'(CHANNELS)) begin
            pageKind = fsr_pkg::FSR_PAGE_CHAN;
        end else begin
            pageKind = fsr_pkg::FSR_PAGE_BAD;
        end
    endfunction

    fsr_pkg::fsr_page_kind_t reqKind;
    logic [CH_W-1:0]         reqChan;
    logic                    cmdKnown;
    logic                    cmdPaged;

    assign reqKind = pageKind(readPage);
    assign reqChan = readPage[CH_W-1:0];

    // Only the six status commands are served here.
    assign cmdKnown = readCmd inside {`FSR_CMD_SUMMARY, `FSR_CMD_VOUT_STATUS, `FSR_CMD_TEMP_STATUS,
                                      `FSR_CMD_COMM_STATUS, `FSR_CMD_VENDOR, `FSR_CMD_MEAS_VOUT};

    // Measured voltage needs a real channel; the others accept page 255.
    assign cmdPaged = (readCmd == `FSR_CMD_MEAS_VOUT);

    logic badCmdEvent;
    logic badPageEvent;
    assign badCmdEvent  = readReq && !cmdKnown;
    assign badPageEvent = readReq && cmdKnown &&
                          (reqKind == fsr_pkg::FSR_PAGE_BAD ||
                           (cmdPaged && reqKind == fsr_pkg::FSR_PAGE_GLOBAL));

    // ----------
    // Latched status flags
    // ----------

    logic [CHANNELS-1:0] ovFaultFlag;
    logic [CHANNELS-1:0] ovWarnFlag;
    logic [CHANNELS-1:0] uvWarnFlag;
    logic [CHANNELS-1:0] uvFaultFlag;
    logic [CHANNELS-1:0] tonFlag;
    logic [CHANNELS-1:0] marginFlag;
    logic [1:0]          tempFlag;
    logic [1:0]          commFlag;
    logic [2:0]          globalFlag;

    // Level conditions re-set right after a clear while they persist.
    fsr_sticky #(.WIDTH(4*CHANNELS)) uVoutLevels (
        .clock    (clock),
        .reset_n  (reset_n),
        .setBits  ({ovFault, ovWarn, uvWarn, uvFault}),
        .clearAll (clearFaults),
        .flags_q  ({ovFaultFlag, ovWarnFlag, uvWarnFlag, uvFaultFlag})
    );

    // Turn-on time and margining are events: set in every cycle their input is high.
    fsr_sticky #(.WIDTH(2*CHANNELS)) uChanEvents (
        .clock    (clock),
        .reset_n  (reset_n),
        .setBits  ({turnOnTimeFault, marginFault}),
        .clearAll (clearFaults),
        .flags_q  ({tonFlag, marginFlag})
    );

    // Temperature levels, communication events and global events share one latch.
    fsr_sticky #(.WIDTH(7)) uGlobal (
        .clock    (clock),
        .reset_n  (reset_n),
        .setBits  ({otFault, otWarn, badCmdEvent, badDataEvent || badPageEvent,
                    faultInputEvent, watchdogResetEvent, controlOffEvent}),
        .clearAll (clearFaults),
        .flags_q  ({tempFlag, commFlag, globalFlag})
    );

    // ----------
    // Unlatched channel state
    // ----------

    logic [CHANNELS-1:0] pgLost_q;
    logic [CHANNELS-1:0] chanOff_q;
    logic                logFull_q;

    // Hysteresis between the two thresholds; reset starts every channel
    // as lost so a supply never reads good before it was seen good.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pgLost_q <= '1;
        end else begin
            pgLost_q <= (pgLost_q | belowGoodOff) & ~aboveGoodOn;
        end
    end

    // Disabled channels never report off.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            chanOff_q <= '0;
        end else begin
            chanOff_q <= channelEnabled & ~supplyEnableOutput;
        end
    end

    // Follows the log live; with overwrite on, freed space clears it at
    // once even if the log source is a cycle late to drop its flag.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            logFull_q <= 1'b0;
        end else begin
            logFull_q <= logFull && !(logOverwriteEnable && logSpaceFreed);
        end
    end

    // ----------
    // Voltage measurement refresh
    // ----------

    logic [CNT_W-1:0] refreshCnt_q;
    logic             refreshTick;
    logic [15:0]      measStore_q [CHANNELS];

    assign refreshTick = (refreshCnt_q == CNT_W'(REFRESH_CYCLES - 1));

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            refreshCnt_q <= '0;
        end else if (refreshTick) begin
            refreshCnt_q <= '0;
        end else begin
            refreshCnt_q <= refreshCnt_q + 1'b1;
        end
    end

    // Readings change only on the tick, so a read never sees a half
    // update between its two bytes.
    for (genvar c = 0; c < CHANNELS; c++) begin : gMeas
        always_ff @(posedge clock or negedge reset_n) begin
            if (!reset_n) begin
                measStore_q[c] <= '0;
            end else if (refreshTick) begin
                measStore_q[c] <= measuredVolts[c*16 +: 16];
            end
        end
    end

    // ----------
    // Status byte assembly
    // ----------

    logic [7:0]  voutByte;
    logic [7:0]  tempByte;
    logic [7:0]  commByte;
    logic [7:0]  vendorByte;
    logic [7:0]  globalByte;
    logic [15:0] summary;
    logic        selOv;
    logic        selVout;
    logic        selMargin;

    // On the global page the voltage fields and margin bit summarise every channel; the vendor byte carries the global byte.
    always_comb begin
        voutByte = '0;
        vendorByte = '0;
        if (reqKind == fsr_pkg::FSR_PAGE_CHAN) begin
            voutByte[`FSR_VOUT_OVF]    = ovFaultFlag[reqChan];
            voutByte[`FSR_VOUT_OVW]    = ovWarnFlag[reqChan];
            voutByte[`FSR_VOUT_UVW]    = uvWarnFlag[reqChan];
            voutByte[`FSR_VOUT_UVF]    = uvFaultFlag[reqChan];
            voutByte[`FSR_VOUT_TON]    = tonFlag[reqChan];
            vendorByte[`FSR_VCH_OFF]    = chanOff_q[reqChan];
            vendorByte[`FSR_VCH_MARGIN] = marginFlag[reqChan];
            vendorByte[`FSR_VCH_PGLOST] = pgLost_q[reqChan];
            selMargin = marginFlag[reqChan];
        end else begin
            voutByte[`FSR_VOUT_OVF]    = |ovFaultFlag;
            voutByte[`FSR_VOUT_OVW]    = |ovWarnFlag;
            voutByte[`FSR_VOUT_UVW]    = |uvWarnFlag;
            voutByte[`FSR_VOUT_UVF]    = |uvFaultFlag;
            voutByte[`FSR_VOUT_TON]    = |tonFlag;
            vendorByte                 = globalByte;
            selMargin = |marginFlag;
        end
    end

    // Unused positions stay at zero from the defaults below.
    always_comb begin
        globalByte = '0;
        globalByte[`FSR_VGL_LOCK]     = deviceLocked;
        globalByte[`FSR_VGL_FAULTIN]  = globalFlag[2];
        globalByte[`FSR_VGL_WATCHDOG] = globalFlag[1];
        globalByte[`FSR_VGL_CONTROL]  = globalFlag[0];
        tempByte = '0;
        tempByte[`FSR_TEMP_OTF] = tempFlag[1];
        tempByte[`FSR_TEMP_OTW] = tempFlag[0];
        commByte = '0;
        commByte[`FSR_COMM_CMD]     = commFlag[1];
        commByte[`FSR_COMM_DATA]    = commFlag[0];
        commByte[`FSR_COMM_LOGFULL] = logFull_q;
    end

    assign selOv   = voutByte[`FSR_VOUT_OVF];
    assign selVout = |voutByte;

    always_comb begin
        summary = '0;
        summary[`FSR_SUM_VOUT]    = selVout;
        summary[`FSR_SUM_VENDOR]  = |globalByte;
        summary[`FSR_SUM_PGLOST]  = |pgLost_q;
        summary[`FSR_SUM_MARGIN]  = selMargin;
        summary[`FSR_SUM_CHANOFF] = |chanOff_q;
        summary[`FSR_SUM_OVFAULT] = selOv;
        summary[`FSR_SUM_TEMP]    = |tempByte;
        summary[`FSR_SUM_COMM]    = |commByte;
    end

    // ----------
    // Read answer
    // ----------

    logic [15:0] readMux;

    // Byte commands answer in the low byte; refused reads answer zero.
    always_comb begin
        readMux = '0;
        if (cmdKnown && !badPageEvent) begin
            case (readCmd)
                `FSR_CMD_SUMMARY:     readMux = summary;
                `FSR_CMD_VOUT_STATUS: readMux = {8'h00, voutByte};
                `FSR_CMD_TEMP_STATUS: readMux = {8'h00, tempByte};
                `FSR_CMD_COMM_STATUS: readMux = {8'h00, commByte};
                `FSR_CMD_VENDOR:      readMux = {8'h00, vendorByte};
                `FSR_CMD_MEAS_VOUT:   readMux = measStore_q[reqChan];
                default:              readMux = '0;
            endcase
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            readValid_q <= 1'b0;
            readData_q  <= '0;
        end else begin
            readValid_q <= readReq;
            readData_q  <= readReq ? readMux : readData_q;
        end
    end

    // ----------
    // Alert
    // ----------

    logic [6*CHANNELS+6:0] alertSrc;
    logic [6*CHANNELS+6:0] alertSrc_q;

    // Off, power-good-lost and lock are left out on purpose. Only a new
    // rising source alerts, so a condition still present at a clear does
    // not bring the alert back.
    assign alertSrc = {ovFault, ovWarn, uvWarn, uvFault, turnOnTimeFault, marginFault,
                       otFault, otWarn, badCmdEvent, badDataEvent || badPageEvent,
                       faultInputEvent, watchdogResetEvent, controlOffEvent};

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            alertSrc_q <= '0;
        end else begin
            alertSrc_q <= alertSrc;
        end
    end

    // A new event in the clearing cycle keeps the alert up.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            alertActive_q <= 1'b0;
        end else begin
            alertActive_q <= (alertActive_q && !clearFaults) ||
                             (|(alertSrc & ~alertSrc_q));
        end
    end

endmodule

// file: test/fsr_status_chk.sv
`timescale 1ns/10ps
`include "fsr_consts.svh"

// ---------------------------------------------------------------------
// Port checks of the status bank
// ---------------------------------------------------------------------
module fsr_status_chk #(
    parameter int CHANNELS = 16
) (
    // Clock and reset
    input wire logic        clock,
    input wire logic        reset_n,
    // Read request and answer
    input wire logic        readReq,
    input wire logic [7:0]  readCmd,
    input wire logic [7:0]  readPage,
    input wire logic        readValid_q,
    input wire logic [15:0] readData_q,
    // Condition inputs
    input wire logic        otWarn,
    input wire logic        logFull,
    input wire logic        logOverwriteEnable
);
    // A bad page answers zero, so bit checks need a good page.
    logic pageOk;
    logic cmdOk;
    assign pageOk = (32'(readPage) < CHANNELS) || (readPage == `FSR_PAGE_GLOBAL);
    assign cmdOk  = readCmd inside {8'h79, 8'h7A, 8'h7D, 8'h7E, 8'h80, 8'h8B};

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    sequence s_take(logic [7:0] code);
        readReq && readCmd == code && pageOk;
    endsequence
    sequence s_log_read;
        s_take(`FSR_CMD_COMM_STATUS) ##0 logFull && $past(logFull)
            && !logOverwriteEnable && !$past(logOverwriteEnable);
    endsequence

    property p_answer;
        readReq |=> readValid_q;
    endproperty
    a_answer: assert property (p_answer) else $error("read not answered");
    property p_hold;
        !readReq |=> !readValid_q && $stable(readData_q);
    endproperty
    a_hold: assert property (p_hold) else $error("answer moved unasked");
    property p_sum_zero;
        s_take(`FSR_CMD_SUMMARY) |=> (readData_q & 16'h6699) == 16'h0000;
    endproperty
    a_sum_zero: assert property (p_sum_zero) else $error("summary spare bit");
    property p_vout_zero;
        s_take(`FSR_CMD_VOUT_STATUS) |=> (readData_q & 16'hFF0B) == 16'h0000;
    endproperty
    a_vout_zero: assert property (p_vout_zero) else $error("vout spare bit");
    property p_temp_zero;
        s_take(`FSR_CMD_TEMP_STATUS) |=> (readData_q & 16'hFF3F) == 16'h0000;
    endproperty
    a_temp_zero: assert property (p_temp_zero) else $error("temp spare bit");
    property p_comm_zero;
        s_take(`FSR_CMD_COMM_STATUS) |=> (readData_q & 16'hFF3E) == 16'h0000;
    endproperty
    a_comm_zero: assert property (p_comm_zero) else $error("comm spare bit");
    property p_log_live;
        s_log_read |=> readValid_q && readData_q[`FSR_COMM_LOGFULL];
    endproperty
    a_log_live: assert property (p_log_live) else $error("log full not shown");
    property p_temp_sum;
        s_take(`FSR_CMD_SUMMARY) ##0 $past(otWarn) |=> readData_q[`FSR_SUM_TEMP];
    endproperty
    a_temp_sum: assert property (p_temp_sum) else $error("temp summary low");
    property p_bad_cmd;
        readReq && !cmdOk |=> readData_q == 16'h0000;
    endproperty
    a_bad_cmd: assert property (p_bad_cmd) else $error("unknown code answered");
endmodule

bind fsr_status_bank fsr_status_chk #(.CHANNELS(CHANNELS)) u_chk (
    .clock(clock), .reset_n(reset_n), .readReq(readReq), .readCmd(readCmd),
    .readPage(readPage), .readValid_q(readValid_q), .readData_q(readData_q),
    .otWarn(otWarn), .logFull(logFull), .logOverwriteEnable(logOverwriteEnable));

// file: test/fsr_host_model.sv
`timescale 1ns/10ps

// ---------------------------------------------------------------------
// Host that selects a page and reads or clears status
// ---------------------------------------------------------------------
module fsr_host_model (
    // Clock
    input wire logic  clock,
    // Requests to the bank
    output logic       readReq,
    output logic [7:0] readCmd,
    output logic [7:0] readPage,
    output logic       clearFaults
);
    // Idle at time zero so the bank never sees an unknown request.
    initial begin
        readReq = 1'b0;
        readCmd = 8'h00;
        readPage = 8'h00;
        clearFaults = 1'b0;
    end

    // Page and code travel with the strobe and are held across the edge.
    task automatic issue(input logic [7:0] cmd, input logic [7:0] page);
        readReq = 1'b1;
        readCmd = cmd;
        readPage = page;
        @(negedge clock);
    endtask

    // Released values are inverted so a stale code is never trusted.
    task automatic stop();
        readReq = 1'b0;
        readCmd = ~readCmd;
        readPage = ~readPage;
        @(negedge clock);
    endtask

    // One-cycle clear, then a quiet cycle for it to land.
    task automatic clear();
        clearFaults = 1'b1;
        @(negedge clock);
        clearFaults = 1'b0;
        @(negedge clock);
    endtask
endmodule

// file: test/testbench.sv
`timescale 1ns/10ps

module testbench;
    localparam int CH  = 16;
    localparam int REF = 8;

    // ----------
    // Signals
    // ----------
    logic               clock = 1'b0;
    logic               reset_n = 1'b0;
    logic               readReq;
    logic [7:0]         readCmd;
    logic [7:0]         readPage;
    logic               clearFaults;
    logic               badDataEvent = 1'b0;
    logic               readValid_q;
    logic [15:0]        readData_q;
    logic               alertActive_q;
    logic [4:0][CH-1:0] vc = '0;
    logic [CH-1:0]      marginFault = '0;
    logic [CH-1:0]      chanOn = '0;
    logic [CH-1:0]      supplyEn = '0;
    logic [CH-1:0]      goodOn = '0;
    logic [CH-1:0]      goodOff = '0;
    logic [CH*16-1:0]   volts = '1;
    logic [1:0]         ot = '0;
    logic [2:0]         logIn = '0;
    logic [3:0]         gev = '0;
    logic [31:0]        rngState = 32'h00010BDD;
    logic [15:0]        expQ[$];
    logic [15:0]        v;
    int                 nFail = 0;
    int                 nChecks = 0;
    int                 c;

    // Half-period toggle gives 50 MHz.
    always #10 clock = ~clock;

    fsr_host_model i_host (.clock(clock), .readReq(readReq), .readCmd(readCmd),
        .readPage(readPage), .clearFaults(clearFaults));

    fsr_status_bank #(.CHANNELS(CH), .REFRESH_CYCLES(REF)) i_dut (
        .clock(clock), .reset_n(reset_n), .readReq(readReq), .readCmd(readCmd),
        .readPage(readPage), .clearFaults(clearFaults), .badDataEvent(badDataEvent),
        .readValid_q(readValid_q), .readData_q(readData_q), .alertActive_q(alertActive_q),
        .ovFault(vc[0]), .ovWarn(vc[1]), .uvWarn(vc[2]), .uvFault(vc[3]),
        .turnOnTimeFault(vc[4]), .marginFault(marginFault), .channelEnabled(chanOn),
        .supplyEnableOutput(supplyEn), .aboveGoodOn(goodOn), .belowGoodOff(goodOff),
        .measuredVolts(volts), .otFault(ot[1]), .otWarn(ot[0]), .logFull(logIn[0]),
        .logOverwriteEnable(logIn[1]), .logSpaceFreed(logIn[2]),
        .deviceLocked(gev[3]), .faultInputEvent(gev[0]),
        .watchdogResetEvent(gev[1]), .controlOffEvent(gev[2]));

    // ----------
    // Helpers
    // ----------
    function automatic logic [31:0] rnd();
        rngState = rngState ^ (rngState << 13);
        rngState = rngState ^ (rngState >> 17);
        rngState = rngState ^ (rngState << 5);
        return rngState;
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        nChecks++;
        if (seen !== exp) begin
            nFail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask

    task automatic rd(input logic [7:0] cmd, input logic [7:0] pg, input logic [15:0] e);
        expQ.push_back(e);
        i_host.issue(cmd, pg);
        i_host.stop();
    endtask

    task automatic finishTest();
        $display("checks %0d failures %0d", nChecks, nFail);
        if (nFail == 0 && nChecks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Each answer is matched against the oldest expectation.
    always @(negedge clock) begin
        if (readValid_q === 1'b1) begin
            if (expQ.size() > 0) begin
                check(readData_q, expQ.pop_front());
            end else begin
                nFail++;
                $display("unexpected answer at %0t: seen %h", $time, readData_q);
            end
        end
    end

    // A hang is cut short well past the expected run length.
    initial begin
        repeat (5000) @(posedge clock);
        nFail++;
        finishTest();
    end

    // ----------
    // Scenarios
    // ----------
    initial begin
        tick(20);
        reset_n = 1'b1;
        rd(8'h8B, 8'h00, 16'h0000);
        rd(8'h79, 8'h00, 16'h0800);
        goodOn = '1;
        tick(1);
        rd(8'h79, 8'h03, 16'h0000);
        goodOn[5] = 1'b0;
        goodOff[5] = 1'b1;
        tick(1);
        rd(8'h80, 8'h05, 16'h0004);
        rd(8'h79, 8'h00, 16'h0800);
        check({15'h0, alertActive_q}, 16'h0000);
        goodOn = '1;
        goodOff = '0;
        chanOn[2] = 1'b1;
        tick(1);
        rd(8'h80, 8'h02, 16'h0080);
        rd(8'h79, 8'h09, 16'h0040);
        check({15'h0, alertActive_q}, 16'h0000);
        supplyEn[2] = 1'b1;
        tick(1);
        rd(8'h80, 8'h02, 16'h0000);
        for (int k = 0; k < 5; k++) begin
            c = int'(rnd() & 32'hF);
            vc[k][c] = 1'b1;
            tick(1);
            vc[k][c] = 1'b0;
            v = (k == 4) ? 16'h0004 : 16'h0080 >> k;
            expQ.push_back(v);
            i_host.issue(8'h7A, 8'(c));
            expQ.push_back((k == 0) ? 16'h8020 : 16'h8000);
            i_host.issue(8'h79, 8'(c));
            i_host.stop();
            i_host.clear();
            rd(8'h7A, 8'(c), 16'h0000);
        end
        vc[1][c] = 1'b1;
        tick(1);
        i_host.clear();
        rd(8'h7A, 8'(c), 16'h0040);
        vc[1][c] = 1'b0;
        i_host.clear();
        ot[0] = 1'b1;
        tick(1);
        ot[0] = 1'b0;
        rd(8'h7D, 8'h00, 16'h0040);
        rd(8'h79, 8'h00, 16'h0004);
        ot[1] = 1'b1;
        i_host.clear();
        rd(8'h7D, 8'h00, 16'h0080);
        ot[1] = 1'b0;
        i_host.clear();
        rd(8'h7D, 8'h00, 16'h0000);
        rd(8'h55, 8'h00, 16'h0000);
        rd(8'h7E, 8'h00, 16'h0080);
        rd(8'h79, 8'h00, 16'h0002);
        i_host.clear();
        rd(8'h7E, 8'h00, 16'h0000);
        badDataEvent = 1'b1;
        tick(1);
        badDataEvent = 1'b0;
        rd(8'h7E, 8'h00, 16'h0040);
        i_host.clear();
        rd(8'h79, 8'h20, 16'h0000);
        rd(8'h7E, 8'h00, 16'h0040);
        i_host.clear();
        logIn[0] = 1'b1;
        i_host.clear();
        rd(8'h7E, 8'h00, 16'h0001);
        logIn[2:1] = 2'h3;
        tick(1);
        rd(8'h7E, 8'h00, 16'h0000);
        logIn = '0;
        i_host.clear();
        gev[3] = 1'b1;
        tick(1);
        rd(8'h80, 8'hFF, 16'h0080);
        rd(8'h79, 8'hFF, 16'h1000);
        rd(8'h80, 8'h00, 16'h0000);
        check({15'h0, alertActive_q}, 16'h0000);
        gev[3] = 1'b0;
        for (int k = 0; k < 3; k++) begin
            gev[k] = 1'b1;
            tick(1);
            gev[k] = 1'b0;
            rd(8'h80, 8'hFF, (k == 0) ? 16'h0040 : 16'h0010 >> (k - 1));
            i_host.clear();
        end
        c = int'(rnd() & 32'hF);
        marginFault[c] = 1'b1;
        tick(1);
        marginFault[c] = 1'b0;
        rd(8'h79, 8'(c), 16'h0100);
        i_host.clear();
        for (int k = 0; k < 3; k++) begin
            c = int'(rnd() & 32'hF);
            v = 16'(rnd() >> 8);
            volts[c*16 +: 16] = v;
            tick(REF + 2);
            rd(8'h8B, 8'(c), v);
        end
        tick(4);
        check(16'(expQ.size()), 16'h0000);
        finishTest();
    end
endmodule
